//--- rtl/mss_pkg.sv
// shared constants for the serial status frame link
package mss_pkg;
    localparam int FRAME_BITS      = 40;
    localparam int DATA_BITS       = 32;
    localparam int ADDR_BITS       = 8;
    localparam int WRITE_SEL_POS   = 39;
    localparam int STATUS_MSB      = 39;
    localparam int STAT_STANDSTILL = 3;
    localparam int STAT_STALL      = 2;
    localparam int STAT_DRV_ERR    = 1;
    localparam int STAT_RESET      = 0;
    localparam int DRV_STANDSTILL  = 31;
    localparam int DRV_STALL       = 24;
    localparam int GLOBAL_STATUS_WORD_DRV_ERR   = 1;
    localparam int GLOBAL_STATUS_WORD_RESET     = 0;
    // input glitch filter: ignore pulses shorter than this
    localparam int FILT_NS         = 20;
    localparam int CLK_PERIOD_NS   = 4;
    localparam int FILT_CYCLES     = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // host sck half period in system cycles; device output lags a fall by
    // about eight cycles and the host adds two sync flops, so 11 is the floor
    localparam int HALF_PERIOD_CYC = 12;
    // host apb register offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_TX_LO   = 8'h04;
    localparam logic [7:0] REG_TX_HI   = 8'h08;
    localparam logic [7:0] REG_RX_LO   = 8'h0C;
    localparam logic [7:0] REG_RX_HI   = 8'h10;
    localparam logic [7:0] REG_STATUS  = 8'h14;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

//--- rtl/mss_link_if.sv
// serial link wires between host and device ends
`timescale 1ns/1ps
interface mss_link_if;
    logic sck;
    logic chip_select_n;
    logic sdi;
    logic sdo_out;
    logic sdo_oe;
    logic sdo;
    // undriven data out is replaced by a constant 1; the bench sees a high
    assign sdo = sdo_oe ? sdo_out : 1'b1;
    modport device_end
    (
        input  sck,
        input  chip_select_n,
        input  sdi,
        output sdo_out,
        output sdo_oe
    );
    modport host_end
    (
        output sck,
        output chip_select_n,
        output sdi,
        input  sdo
    );
endinterface

//--- rtl/mss_device.sv
// device end: serial slave returning status byte and pipelined data
//
// Overview of operation
// (R1) status latched at frame end, sent next
// (R2) status byte in reply bits 39..32
// (R3) status bit 3 is standstill flag
// (R4) status bit 2 is stall flag
// (R5) status bit 1 driver error, read-cleared
// (R6) status bit 0 reset flag, read-cleared
// (R7) data field right aligned
// (R8) act only while chip select low
// (R9) sample rising sck, drive after falling
// (R10) most significant bit first
// (R11) host gives at least forty clocks
// (R12) surplus bits leave delayed forty clocks
// (R13) host holds select low whole frame
// (R14) select rising commits shift register
// (R15) only last forty bits count
// (R16) host sck at most half mclk
// (R17) filter input pulses under 20 ns
// (R18) mode 3, clock idles high
// (R19) host limits sck frequency
// (R20) frame: rw address byte plus data
// (R21) read data returned one frame later
// (R22) write data echoed in next frame
// (R23) data out released while deselected
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module mss_device
#(
    parameter int FILT_LEN = mss_pkg::FILT_CYCLES
)
(
    input  wire logic                           mclk,
    input  wire logic                           rst_n,
    mss_link_if.device_end                      link,
    input  wire logic                           driver_enable_low,
    input  wire logic [mss_pkg::DATA_BITS-1:0]  driver_state_word,
    input  wire logic                           drv_error_event,
    output logic                                drv_enable_filt_n,
    output logic                                cmd_valid,
    output logic                                cmd_write,
    output logic [6:0]                          cmd_addr,
    output logic [mss_pkg::DATA_BITS-1:0]       cmd_data,
    input  wire logic [mss_pkg::DATA_BITS-1:0]  rd_data
);
    import mss_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers and glitch filters
    // ------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] filt_reg;
    logic [3:0] filt_prev_reg;
    logic [3:0][7:0] filt_cnt_reg;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 4'hF;
            sync2_reg <= 4'hF;
        end
        else
        begin
            sync1_reg <= {driver_enable_low, link.sdi, link.chip_select_n, link.sck};
            sync2_reg <= sync1_reg;
        end
    end

    // a level must persist FILT_LEN cycles before it is accepted
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filt_reg     <= 4'hF;
            filt_cnt_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (sync2_reg[i] == filt_reg[i])
                begin
                    filt_cnt_reg[i] <= 8'h00;
                end
                else if (filt_cnt_reg[i] >= 8'(FILT_LEN - 1))
                begin
                    filt_reg[i]     <= sync2_reg[i]; // [R17]
                    filt_cnt_reg[i] <= 8'h00;
                end
                else
                begin
                    filt_cnt_reg[i] <= filt_cnt_reg[i] + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filt_prev_reg <= 4'hF;
        end
        else
        begin
            filt_prev_reg <= filt_reg;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic selected;
    assign selected = !filt_reg[1];                                  // [R8]
    assign sck_rise = filt_reg[0] && !filt_prev_reg[0] && selected;  // [R18]
    assign sck_fall = !filt_reg[0] && filt_prev_reg[0] && selected;
    assign cs_rise  = filt_reg[1] && !filt_prev_reg[1];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv_enable_filt_n <= 1'b1;
        end
        else
        begin
            drv_enable_filt_n <= filt_reg[3];
        end
    end

    // ------------------------------------------------------------
    // global status flags
    // ------------------------------------------------------------
    logic [1:0] global_status_word_reg;
    logic       global_status_word_read;
    logic [FRAME_BITS-1:0] shift_reg;
    assign global_status_word_read = cs_rise && !shift_reg[WRITE_SEL_POS] && shift_reg[38:32] == 7'h01;

    // reset flag starts set; new events win over the read-clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            global_status_word_reg <= 2'b01;
        end
        else
        begin
            global_status_word_reg[GLOBAL_STATUS_WORD_DRV_ERR] <= drv_error_event ||
                                        (global_status_word_reg[GLOBAL_STATUS_WORD_DRV_ERR] && !global_status_word_read); // [R5]
            global_status_word_reg[GLOBAL_STATUS_WORD_RESET]   <= global_status_word_reg[GLOBAL_STATUS_WORD_RESET] && !global_status_word_read;     // [R6]
        end
    end

    // ------------------------------------------------------------
    // shift register, reply and commit
    // ------------------------------------------------------------
    logic [DATA_BITS-1:0] reply_data_reg;
    logic [7:0]           status_reg;
    logic                 in_frame_reg;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg    <= '0;
            in_frame_reg <= 1'b0;
        end
        else if (!selected)
        begin
            in_frame_reg <= 1'b0;
        end
        else if (!in_frame_reg)
        begin
            // load reply as select falls; top bit appears at once
            shift_reg    <= {status_reg, reply_data_reg}; // [R2] [R7]
            in_frame_reg <= 1'b1;
        end
        else if (sck_rise)
        begin
            // old top bit stays on the output until the next falling edge
            shift_reg <= {shift_reg[FRAME_BITS-2:0], filt_reg[2]}; // [R9] [R10] [R12]
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.sdo_out <= 1'b1;
            link.sdo_oe  <= 1'b0;
        end
        else
        begin
            link.sdo_oe <= selected; // [R23]
            if (selected && !in_frame_reg)
            begin
                link.sdo_out <= status_reg[7];
            end
            else if (sck_fall)
            begin
                link.sdo_out <= shift_reg[FRAME_BITS-1]; // [R9]
            end
        end
    end

    // commit last forty bits and latch status for the next frame
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_valid      <= 1'b0;
            cmd_write      <= 1'b0;
            cmd_addr       <= '0;
            cmd_data       <= '0;
            reply_data_reg <= RESET_WORD;
            status_reg     <= '0;
        end
        else
        begin
            cmd_valid <= 1'b0;
            if (cs_rise)
            begin
                cmd_valid  <= 1'b1;                          // [R14] [R15]
                cmd_write  <= shift_reg[WRITE_SEL_POS];      // [R20]
                cmd_addr   <= shift_reg[38:32];
                cmd_data   <= shift_reg[DATA_BITS-1:0];
                status_reg <= {4'h0,
                               driver_state_word[DRV_STANDSTILL], // [R3]
                               driver_state_word[DRV_STALL],      // [R4]
                               global_status_word_reg};                        // [R1]
                if (shift_reg[WRITE_SEL_POS])
                begin
                    reply_data_reg <= shift_reg[DATA_BITS-1:0]; // [R22]
                end
                else if (shift_reg[38:32] == 7'h01)
                begin
                    reply_data_reg <= {30'h0, global_status_word_reg};
                end
                else
                begin
                    reply_data_reg <= rd_data; // [R21]
                end
            end
        end
    end
endmodule

//--- rtl/mss_host.sv
// host end: apb-controlled serial master for 40-bit mode 3 frames
`timescale 1ns/1ps
module mss_host
#(
    parameter int HALF_CYC = mss_pkg::HALF_PERIOD_CYC
)
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    mss_link_if.host_end     link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import mss_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_GAP} mss_state_type;
    mss_state_type state_reg;

    logic [39:0] tx_reg;
    logic [39:0] rx_reg;
    logic [39:0] sh_reg;
    logic [5:0]  bit_cnt_reg;
    logic [7:0]  div_reg;
    logic        done_reg;
    logic        sdo_s1_reg;
    logic        sdo_s2_reg;
    logic        go;
    logic        tick;

    assign go   = psel && penable && pwrite && paddr == REG_CTRL && pwdata[0]
                  && state_reg == ST_IDLE;
    assign tick = div_reg == 8'(HALF_CYC - 1); // [R16] [R19]

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sdo_s1_reg <= 1'b1;
            sdo_s2_reg <= 1'b1;
        end
        else
        begin
            sdo_s1_reg <= link.sdo;
            sdo_s2_reg <= sdo_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // apb slave: zero wait states
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            tx_reg  <= '0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                if (paddr == REG_CTRL)
                    prdata <= {31'h0, state_reg != ST_IDLE};
                else if (paddr == REG_TX_LO)
                    prdata <= tx_reg[31:0];
                else if (paddr == REG_TX_HI)
                    prdata <= {24'h0, tx_reg[39:32]};
                else if (paddr == REG_RX_LO)
                    prdata <= rx_reg[31:0];
                else if (paddr == REG_RX_HI)
                    prdata <= {24'h0, rx_reg[39:32]};
                else if (paddr == REG_STATUS)
                    prdata <= {30'h0, done_reg, state_reg != ST_IDLE};
                else
                begin
                    prdata  <= '0;
                    pslverr <= 1'b1;
                end
            end
            if (psel && penable && pwrite && state_reg == ST_IDLE)
            begin
                if (paddr == REG_TX_LO)
                    tx_reg[31:0] <= pwdata;
                else if (paddr == REG_TX_HI)
                    tx_reg[39:32] <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // frame sequencer; sck idles high
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg          <= ST_IDLE;
            link.sck           <= 1'b1;
            link.chip_select_n <= 1'b1;
            link.sdi           <= 1'b1;
            sh_reg             <= '0;
            rx_reg             <= '0;
            bit_cnt_reg        <= '0;
            div_reg            <= '0;
            done_reg           <= 1'b0;
        end
        else
        begin
            div_reg <= (state_reg == ST_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
            case (state_reg)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        done_reg           <= 1'b0;
                        link.chip_select_n <= 1'b0; // [R13]
                        link.sdi           <= tx_reg[39]; // [R10]
                        // first falling edge drives bit 39 again, not bit 38
                        sh_reg             <= tx_reg;
                        bit_cnt_reg        <= '0;
                        state_reg          <= ST_HIGH;
                    end
                end
                ST_HIGH:
                begin
                    if (tick)
                    begin
                        link.sck  <= 1'b0;
                        state_reg <= ST_LOW;
                    end
                end
                ST_LOW:
                begin
                    if (tick)
                    begin
                        link.sck <= 1'b1;
                        rx_reg   <= {rx_reg[38:0], sdo_s2_reg};
                        if (bit_cnt_reg == 6'(FRAME_BITS - 1)) // [R11]
                        begin
                            state_reg <= ST_GAP;
                        end
                        else
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 6'h01;
                            state_reg   <= ST_HIGH;
                        end
                    end
                    else if (div_reg == 8'h00)
                    begin
                        link.sdi <= sh_reg[39];
                        sh_reg   <= {sh_reg[38:0], 1'b0};
                    end
                end
                ST_GAP:
                begin
                    if (tick)
                    begin
                        link.chip_select_n <= 1'b1;
                        done_reg           <= 1'b1;
                        state_reg          <= ST_IDLE;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- sim/mss_link_props.sv
// protocol checker for the serial status frame link
`timescale 1ns/1ps
module mss_link_props
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic chip_select_n,
    input wire logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    logic [4:0] cs_hi_reg;
    logic [6:0] rise_reg;
    logic       sck_reg;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // -----------------------------
    // helper counters
    // -----------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cs_hi_reg <= 5'h00;
        else if (!chip_select_n)
            cs_hi_reg <= 5'h00;
        else if (cs_hi_reg != 5'h1F)
            cs_hi_reg <= cs_hi_reg + 5'h01;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            sck_reg <= 1'b1;
        else
            sck_reg <= sck;
    end

    // cleared one cycle after select rises so the frame end still sees the count
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rise_reg <= 7'h00;
        else if (cs_hi_reg == 5'h01)
            rise_reg <= 7'h00;
        else if (sck && !sck_reg && !chip_select_n)
            rise_reg <= rise_reg + 7'h01;
    end

    // -----------------------------
    // assertions
    // -----------------------------
    sdo_release_a: assert property (cs_hi_reg >= 5'h10 |-> !sdo_oe)
        else $error("data out driven while deselected");
    drive_select_a: assert property ($rose(sdo_oe) |-> !chip_select_n)
        else $error("data out enabled without select");
    idle_high_a: assert property ($fell(chip_select_n) |-> sck)
        else $error("frame opened with clock low");
    frame_count_a: assert property ($rose(chip_select_n) |-> sck && rise_reg == 7'h28)
        else $error("frame closed without forty clocks");
    hold_low_a: assert property (rise_reg != 7'h00 && rise_reg != 7'h28 |-> !chip_select_n)
        else $error("select released mid frame");
    sdi_hold_a: assert property ($rose(sck) |-> ##1 $stable(sdi)[*8])
        else $error("data in moved after rising clock");
    sck_low_a: assert property ($fell(sck) |-> (!sck)[*8])
        else $error("clock low phase too short");
    sdo_fall_a: assert property (!chip_select_n && sdo_oe && $past(sdo_oe) && $changed(sdo_out)
        |-> !sck)
        else $error("data out changed while clock high");
endmodule

//--- sim/test_spi_slave_status_frame.sv
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
module test_spi_slave_status_frame;
    import mss_pkg::*;
    localparam logic [39:0] MS = 40'h0F_0000_0000;
    localparam logic [39:0] MD = 40'h00_FFFF_FFFF;
    localparam logic [39:0] MA = 40'h0F_FFFF_FFFF;
    logic        mclk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        driver_enable_low;
    logic [31:0] driver_state_word;
    logic        drv_error_event;
    logic        drv_enable_filt_n;
    logic        cmd_valid;
    logic        cmd_write;
    logic [6:0]  cmd_addr;
    logic [31:0] cmd_data;
    logic [31:0] rd_data;
    logic [39:0] last_cmd;
    logic [31:0] q;
    logic        e;
    logic        f;
    int          n_cmds = 0;
    int          n_errors;
    int          checks_done;

    mss_link_if link_if();
    mss_host mss_host_inst (.mclk(mclk), .rst_n(rst_n), .link(link_if), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    mss_device mss_device_inst (.mclk(mclk), .rst_n(rst_n), .link(link_if),
        .driver_enable_low(driver_enable_low), .driver_state_word(driver_state_word),
        .drv_error_event(drv_error_event), .drv_enable_filt_n(drv_enable_filt_n),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .rd_data(rd_data));
    mss_link_props mss_link_props_inst (.mclk(mclk), .rst_n(rst_n), .sck(link_if.sck),
        .chip_select_n(link_if.chip_select_n), .sdi(link_if.sdi),
        .sdo_out(link_if.sdo_out), .sdo_oe(link_if.sdo_oe));

    // -----------------------------
    // tasks
    // -----------------------------
    always @(posedge mclk)
        if (cmd_valid === 1'b1)
        begin
            last_cmd <= {cmd_write, cmd_addr, cmd_data};
            n_cmds   <= n_cmds + 1;
        end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; idles one cycle so the next call never collides
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            n_errors++;
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic step(input logic [39:0] tx, input logic [39:0] exp, input logic [39:0] msk);
        logic [39:0] rx;
        logic [31:0] r;
        logic        x;
        int          c;
        int          n;
        c = n_cmds;
        apb(1'b1, REG_TX_HI, {24'h000000, tx[39:32]}, r, x);
        apb(1'b1, REG_TX_LO, tx[31:0], r, x);
        apb(1'b1, REG_CTRL, 32'h0000_0001, r, x);
        n = 0;
        do
        begin
            apb(1'b0, REG_STATUS, 32'h0000_0000, r, x);
            n++;
        end
        while (r[1] !== 1'b1 && n < 2000);
        apb(1'b0, REG_RX_HI, 32'h0000_0000, r, x);
        rx[39:32] = r[7:0];
        apb(1'b0, REG_RX_LO, 32'h0000_0000, r, x);
        rx[31:0] = r;
        n = 0;
        while (n_cmds == c && n < 100)
        begin
            @(posedge mclk);
            n++;
        end
        chk(rx & msk, exp & msk);
        chk(last_cmd, tx);
    endtask

    // -----------------------------
    // stimulus
    // -----------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        #300000;
        n_errors++;
        give_verdict();
    end

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        driver_enable_low = 1'b1;
        driver_state_word = 32'h8100_0000;
        drv_error_event = 1'b0;
        rd_data = 32'h1357_9BDF;
        n_errors = 0;
        checks_done = 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        step(40'h90_0001_1F10, 40'h00_0000_0000, MS);
        step(40'h05_0000_0000, 40'h0D_0001_1F10, MA);
        step(40'h01_0000_0000, 40'h0D_1357_9BDF, MA);
        driver_state_word <= 32'h0000_0000;
        step(40'h00_0000_0000, 40'h00_0000_0001, MD);
        step(40'h00_0000_0000, 40'h00_0000_0000, MS);
        $display("test pipeline done");
        drv_error_event <= 1'b1;
        @(posedge mclk);
        drv_error_event <= 1'b0;
        step(40'h00_0000_0000, 40'h00_0000_0000, MS);
        step(40'h01_0000_0000, 40'h02_0000_0000, MS);
        step(40'h00_0000_0000, 40'h00_0000_0002, MD);
        step(40'h00_0000_0000, 40'h00_0000_0000, MS);
        $display("test driver error done");
        apb(1'b0, 8'h40, 32'h0000_0000, q, e);
        chk({7'h00, e, q}, 40'h01_0000_0000);
        $display("test unmapped done");
        // a 8 ns low pulse is shorter than the filter span
        driver_enable_low <= 1'b0;
        repeat (2) @(posedge mclk);
        driver_enable_low <= 1'b1;
        f = 1'b1;
        repeat (12)
        begin
            @(posedge mclk);
            f = f & drv_enable_filt_n;
        end
        chk({39'h0, f}, 40'h01);
        driver_enable_low <= 1'b0;
        repeat (15) @(posedge mclk);
        chk({39'h0, drv_enable_filt_n}, 40'h00);
        driver_enable_low <= 1'b1;
        $display("test enable filter done");
        give_verdict();
    end
endmodule
